// File: shared/lpb_pkg.sv
// Constants shared by the panel bus, interrupt and bring-up block
package lpb_pkg;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [11:0] OFS_UPPER_BASE = 12'h000;
	localparam logic [11:0] OFS_LOWER_BASE = 12'h004;
	localparam logic [11:0] OFS_FRAME_CFG = 12'h018;
	localparam logic [11:0] OFS_FETCH_CTRL = 12'h01C;
	localparam logic [11:0] OFS_WINDOW_CFG = 12'h020;
	localparam logic [11:0] OFS_CTRL_ONE = 12'h800;
	localparam logic [11:0] OFS_CTRL_TWO = 12'h804;
	localparam logic [11:0] OFS_DITHER_FIRST = 12'h81C;
	localparam logic [11:0] OFS_DITHER_LAST = 12'h838;
	localparam logic [11:0] OFS_POWER = 12'h83C;
	localparam logic [11:0] OFS_IRQ_ENABLE = 12'h848;
	localparam logic [11:0] OFS_IRQ_DISABLE = 12'h84C;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h850;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h854;
	localparam logic [11:0] OFS_IRQ_CLEAR = 12'h858;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [31:0] RST_CTRL_ONE = 32'h0000_2000;
	localparam logic [31:0] RST_POWER = 32'h0000_000E;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] RST_DITHER [8] = '{32'h0000_00A5, 32'h05AF_0FA5,
		32'h000A_5A5F, 32'h0000_0A5F, 32'h0FAF_5FA5, 32'h0000_FAF5,
		32'h000F_AF5F, 32'h0F5F_FAFF};
	// ****************************************
	// Field positions
	// ****************************************
	localparam int FETCH_ENABLE_BIT = 0;
	localparam int FETCH_COMMIT_BIT = 2;
	localparam int WINDOW_EN_BIT = 3;
	localparam int BYPASS_BIT = 0;
	localparam int DIVISOR_LSB = 12;
	localparam int DIVISOR_W = 9;
	localparam int TYPE_LSB = 0;
	localparam int DUAL_SCAN_BIT = 2;
	localparam int WIDTH_LSB = 3;
	localparam int POWER_EN_BIT = 0;
	localparam int BUSY_BIT = 31;
	localparam int IRQ_W = 6;
	// Interrupt source bit positions
	localparam int IRQ_LINE = 0;
	localparam int IRQ_LAST_LINE = 1;
	localparam int IRQ_FRAME = 2;
	localparam int IRQ_UNDERFLOW = 3;
	localparam int IRQ_OVERWRITE = 4;
	localparam int IRQ_MEM_ERR = 5;
	// Panel kinds and interface widths
	localparam logic [1:0] TYPE_TFT = 2'h2;
	localparam logic [1:0] WIDTH_4 = 2'h0;
	localparam logic [1:0] WIDTH_8 = 2'h1;
	localparam logic [1:0] WIDTH_16 = 2'h2;
	// Bus answer states, one-hot
	typedef enum logic [1:0] {
		LPB_IDLE = 2'h1,
		LPB_ANSWER = 2'h2
	} lpb_bus_state_t;
endpackage

// File: rtl/lpb_core.sv
// Panel data bus lanes, interrupt sources and fetch/core bring-up logic
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
module lpb_core (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [11:0] i_avm_address,
	input wire logic i_avm_read,
	input wire logic i_avm_write,
	input wire logic [31:0] i_avm_writedata,
	output logic [31:0] o_avm_readdata,
	output logic o_avm_waitrequest,
	input wire logic i_bus_error,
	input wire logic i_fetch_transfer,
	input wire logic i_serializer_read,
	input wire logic i_fifo_empty,
	input wire logic i_fetch_fifo_write,
	input wire logic i_fifo_full,
	input wire logic i_frame_reload,
	input wire logic i_line_blank,
	input wire logic i_last_line,
	input wire logic i_fetch_idle,
	input wire logic [7:0] i_pix_upper,
	input wire logic [7:0] i_pix_lower,
	input wire logic [7:0] i_pix_red,
	input wire logic [7:0] i_pix_green,
	input wire logic [7:0] i_pix_blue,
	output logic [23:0] o_panel_data_bus,
	output logic o_pixel_clock_out,
	output logic o_fetch_run,
	output logic [31:0] o_upper_frame_base,
	output logic [31:0] o_lower_frame_base,
	output logic [31:0] o_fetch_frame_config,
	output logic [31:0] o_window_addressing_config,
	output logic o_irq
);
	// ****************************************
	// Registers
	// ****************************************
	lpb_pkg::lpb_bus_state_t state_r; // Bus answer state
	logic [31:0] upper_base_r; // Software view of upper base
	logic [31:0] lower_base_r; // Software view of lower base
	logic [31:0] frame_cfg_r; // Frame word count and burst length
	logic [31:0] fetch_ctrl_r; // Fetch control, commit bit reads zero
	logic [31:0] window_cfg_r; // Window addressing configuration
	logic [31:0] ctrl_one_r; // Divisor and bypass
	logic [31:0] ctrl_two_r; // Panel kind, scan, width
	logic [31:0] dither_r [8]; // Dither patterns
	logic [31:0] power_r; // Power control without busy bit
	logic busy_r; // Core not yet idle
	logic commit_pend_r; // Commit written, waiting for the applied set to load (at reload or while fetch is stopped)
	logic [lpb_pkg::IRQ_W-1:0] mask_r; // Enabled sources
	logic [lpb_pkg::IRQ_W-1:0] status_r; // Pending sources
	logic [lpb_pkg::IRQ_W-1:0] event_r; // Events caught on core clock
	logic [lpb_pkg::DIVISOR_W-1:0] div_cnt_r; // Pixel clock divider
	logic [31:0] rdata_nxt; // Read mux
	logic wr_fire; // Write takes effect this edge
	logic rd_take; // Read data captured at this edge
	logic core_on; // Core power enable field
	logic dual_scan; // Dual scan selected
	logic hold_cfg; // Changes need the commit bit
	logic apply_cfg; // Applied set loads at this edge
	logic [lpb_pkg::IRQ_W-1:0] ev_raw; // Raw interrupt causes

	assign core_on = power_r[lpb_pkg::POWER_EN_BIT];
	assign dual_scan = ctrl_two_r[lpb_pkg::DUAL_SCAN_BIT];
	assign hold_cfg = dual_scan | fetch_ctrl_r[lpb_pkg::WINDOW_EN_BIT];
	assign apply_cfg = (i_frame_reload || !o_fetch_run) && (!hold_cfg || commit_pend_r);
	assign wr_fire = i_avm_write & (state_r == lpb_pkg::LPB_ANSWER);
	assign rd_take = i_avm_read & (state_r == lpb_pkg::LPB_IDLE);

	// Word decode helper
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction

	// ****************************************
	// Avalon slave: one wait cycle per access
	// ****************************************
	// Request seen with wait high, answered the next cycle with wait low
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_r <= lpb_pkg::LPB_IDLE;
			o_avm_waitrequest <= 1'b1;
		end else begin
			case (state_r)
				lpb_pkg::LPB_IDLE: begin
					if (i_avm_read | i_avm_write) begin
						state_r <= lpb_pkg::LPB_ANSWER;
						o_avm_waitrequest <= 1'b0;
					end
				end
				lpb_pkg::LPB_ANSWER: begin
					state_r <= lpb_pkg::LPB_IDLE;
					o_avm_waitrequest <= 1'b1;
				end
				default: begin
					state_r <= lpb_pkg::LPB_IDLE;
					o_avm_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// Read mux; write-only and unmapped words read zero
	always_comb begin
		rdata_nxt = lpb_pkg::RST_ZERO;
		case (i_avm_address)
			lpb_pkg::OFS_UPPER_BASE: rdata_nxt = upper_base_r;
			lpb_pkg::OFS_LOWER_BASE: rdata_nxt = lower_base_r;
			lpb_pkg::OFS_FRAME_CFG: rdata_nxt = frame_cfg_r;
			lpb_pkg::OFS_FETCH_CTRL: rdata_nxt = fetch_ctrl_r;
			lpb_pkg::OFS_WINDOW_CFG: rdata_nxt = window_cfg_r;
			lpb_pkg::OFS_CTRL_ONE: rdata_nxt = ctrl_one_r;
			lpb_pkg::OFS_CTRL_TWO: rdata_nxt = ctrl_two_r;
			lpb_pkg::OFS_POWER: begin
				rdata_nxt = power_r;
				rdata_nxt[lpb_pkg::BUSY_BIT] = busy_r;
			end
			lpb_pkg::OFS_IRQ_MASK: rdata_nxt = {26'h0, mask_r};
			lpb_pkg::OFS_IRQ_STATUS: rdata_nxt = {26'h0, status_r};
			default: begin
				for (int k = 0; k < 8; k++) begin
					if (i_avm_address == lpb_pkg::OFS_DITHER_FIRST + 12'(4 * k)) begin
						rdata_nxt = dither_r[k];
					end
				end
			end
		endcase
	end

	// Read data captured at request so it stands when wait drops
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_avm_readdata <= lpb_pkg::RST_ZERO;
		end else if (rd_take) begin
			o_avm_readdata <= rdata_nxt;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	// Read/write registers, commit and busy bits stored as zero; dither patterns preset at reset
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			upper_base_r <= lpb_pkg::RST_ZERO;
			lower_base_r <= lpb_pkg::RST_ZERO;
			frame_cfg_r <= lpb_pkg::RST_ZERO;
			fetch_ctrl_r <= lpb_pkg::RST_ZERO;
			window_cfg_r <= lpb_pkg::RST_ZERO;
			ctrl_one_r <= lpb_pkg::RST_CTRL_ONE;
			ctrl_two_r <= lpb_pkg::RST_ZERO;
			power_r <= lpb_pkg::RST_POWER;
			dither_r <= lpb_pkg::RST_DITHER;
		end else if (wr_fire) begin
			if (hit(i_avm_address, lpb_pkg::OFS_UPPER_BASE)) upper_base_r <= i_avm_writedata;
			if (hit(i_avm_address, lpb_pkg::OFS_LOWER_BASE)) lower_base_r <= i_avm_writedata;
			if (hit(i_avm_address, lpb_pkg::OFS_FRAME_CFG)) frame_cfg_r <= i_avm_writedata;
			if (hit(i_avm_address, lpb_pkg::OFS_WINDOW_CFG)) window_cfg_r <= i_avm_writedata;
			if (hit(i_avm_address, lpb_pkg::OFS_CTRL_ONE)) ctrl_one_r <= i_avm_writedata;
			if (hit(i_avm_address, lpb_pkg::OFS_CTRL_TWO)) ctrl_two_r <= i_avm_writedata;
			if (hit(i_avm_address, lpb_pkg::OFS_POWER)) begin
				power_r <= i_avm_writedata;
				power_r[lpb_pkg::BUSY_BIT] <= 1'b0;
			end
			if (hit(i_avm_address, lpb_pkg::OFS_FETCH_CTRL)) begin
				fetch_ctrl_r <= i_avm_writedata;
				fetch_ctrl_r[lpb_pkg::FETCH_COMMIT_BIT] <= 1'b0;
			end
			for (int k = 0; k < 8; k++) begin
				if (hit(i_avm_address, lpb_pkg::OFS_DITHER_FIRST + 12'(4 * k))) begin
					dither_r[k] <= i_avm_writedata;
				end
			end
		end
	end

	// ****************************************
	// Fetch configuration and bring-up
	// ****************************************
	// Commit request waits until the applied set takes it, then is spent
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			commit_pend_r <= 1'b0;
		end else if (wr_fire && hit(i_avm_address, lpb_pkg::OFS_FETCH_CTRL)
			&& i_avm_writedata[lpb_pkg::FETCH_COMMIT_BIT]) begin
			commit_pend_r <= 1'b1;
		end else if (apply_cfg) begin
			commit_pend_r <= 1'b0;
		end
	end

	// Applied set loads at reload or while fetch is stopped; dual or window mode needs commit
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_upper_frame_base <= lpb_pkg::RST_ZERO;
			o_lower_frame_base <= lpb_pkg::RST_ZERO;
			o_fetch_frame_config <= lpb_pkg::RST_ZERO;
			o_window_addressing_config <= lpb_pkg::RST_ZERO;
		end else if (apply_cfg) begin
			o_upper_frame_base <= upper_base_r;
			o_lower_frame_base <= dual_scan ? lower_base_r : lpb_pkg::RST_ZERO;
			o_fetch_frame_config <= frame_cfg_r;
			o_window_addressing_config <= fetch_ctrl_r[lpb_pkg::WINDOW_EN_BIT]
				? window_cfg_r : lpb_pkg::RST_ZERO;
		end
	end

	// Fetch runs only with fetch enabled and core powered
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_fetch_run <= 1'b0;
		end else begin
			o_fetch_run <= fetch_ctrl_r[lpb_pkg::FETCH_ENABLE_BIT] & core_on;
		end
	end

	// Busy rises with power; after power-off it falls at the next idle blanking
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			busy_r <= 1'b0;
		end else if (core_on) begin
			busy_r <= 1'b1;
		end else if (i_line_blank && i_fetch_idle) begin
			busy_r <= 1'b0;
		end
	end

	// ****************************************
	// Pixel clock
	// ****************************************
	// Output toggles every divisor+1 cycles; bypass toggles every cycle
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			div_cnt_r <= '0;
			o_pixel_clock_out <= 1'b0;
		end else if (!busy_r) begin
			div_cnt_r <= '0;
			o_pixel_clock_out <= 1'b0;
		end else if (ctrl_one_r[lpb_pkg::BYPASS_BIT]) begin
			div_cnt_r <= '0;
			o_pixel_clock_out <= ~o_pixel_clock_out;
		end else if (div_cnt_r >= ctrl_one_r[lpb_pkg::DIVISOR_LSB +: lpb_pkg::DIVISOR_W]) begin
			div_cnt_r <= '0;
			o_pixel_clock_out <= ~o_pixel_clock_out;
		end else begin
			div_cnt_r <= div_cnt_r + 1'b1;
		end
	end

	// ****************************************
	// Panel data lanes
	// ****************************************
	// Lane assignment by panel kind, scan and width
	always_ff @(posedge i_clock) begin
		if (i_rst || !core_on) begin
			o_panel_data_bus <= 24'h00_0000;
		end else if (ctrl_two_r[lpb_pkg::TYPE_LSB +: 2] == lpb_pkg::TYPE_TFT) begin
			o_panel_data_bus <= {i_pix_blue, i_pix_green, i_pix_red};
		end else if (dual_scan && ctrl_two_r[lpb_pkg::WIDTH_LSB +: 2] == lpb_pkg::WIDTH_16) begin
			o_panel_data_bus <= {8'h00, i_pix_lower, i_pix_upper};
		end else if (dual_scan) begin
			o_panel_data_bus <= {16'h0000, i_pix_lower[3:0], i_pix_upper[3:0]};
		end else if (ctrl_two_r[lpb_pkg::WIDTH_LSB +: 2] == lpb_pkg::WIDTH_4) begin
			o_panel_data_bus <= {20'h0_0000, i_pix_upper[3:0]};
		end else begin
			o_panel_data_bus <= {16'h0000, i_pix_upper};
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	// Raw causes, caught on the core clock one cycle before status
	always_comb begin
		ev_raw = '0;
		ev_raw[lpb_pkg::IRQ_MEM_ERR] = i_bus_error & i_fetch_transfer;
		ev_raw[lpb_pkg::IRQ_UNDERFLOW] = i_serializer_read & i_fifo_empty;
		ev_raw[lpb_pkg::IRQ_OVERWRITE] = i_fetch_fifo_write & i_fifo_full;
		ev_raw[lpb_pkg::IRQ_FRAME] = i_frame_reload;
		ev_raw[lpb_pkg::IRQ_LINE] = i_line_blank & i_fetch_idle;
		ev_raw[lpb_pkg::IRQ_LAST_LINE] = i_line_blank & i_last_line & i_fetch_idle;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			event_r <= '0;
		end else begin
			event_r <= ev_raw;
		end
	end

	// Mask: enable sets, disable clears
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			mask_r <= '0;
		end else if (wr_fire && hit(i_avm_address, lpb_pkg::OFS_IRQ_ENABLE)) begin
			mask_r <= mask_r | i_avm_writedata[lpb_pkg::IRQ_W-1:0];
		end else if (wr_fire && hit(i_avm_address, lpb_pkg::OFS_IRQ_DISABLE)) begin
			mask_r <= mask_r & ~i_avm_writedata[lpb_pkg::IRQ_W-1:0];
		end
	end

	// Status: events set, clear register clears, a new event wins
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			status_r <= '0;
		end else if (wr_fire && hit(i_avm_address, lpb_pkg::OFS_IRQ_CLEAR)) begin
			status_r <= (status_r & ~i_avm_writedata[lpb_pkg::IRQ_W-1:0]) | event_r;
		end else begin
			status_r <= status_r | event_r;
		end
	end

	// Single interrupt line
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(status_r & mask_r);
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_irq_or;
		@(posedge i_clock) disable iff (i_rst) ##1 o_irq == |($past(status_r) & $past(mask_r));
	endproperty
	a_irq_or: assert property (p_irq_or) else $error("irq not OR of masked status");
	property p_mem_err;
		@(posedge i_clock) disable iff (i_rst)
			(i_bus_error && i_fetch_transfer) |-> ##2 status_r[lpb_pkg::IRQ_MEM_ERR];
	endproperty
	a_mem_err: assert property (p_mem_err) else $error("memory error not flagged");
	property p_underflow;
		@(posedge i_clock) disable iff (i_rst)
			(i_serializer_read && i_fifo_empty) |-> ##2 status_r[lpb_pkg::IRQ_UNDERFLOW];
	endproperty
	a_underflow: assert property (p_underflow) else $error("underflow not flagged");
	property p_overwrite;
		@(posedge i_clock) disable iff (i_rst)
			(i_fetch_fifo_write && i_fifo_full) |-> ##2 status_r[lpb_pkg::IRQ_OVERWRITE];
	endproperty
	a_overwrite: assert property (p_overwrite) else $error("overwrite not flagged");
	property p_frame;
		@(posedge i_clock) disable iff (i_rst) i_frame_reload |-> ##2 status_r[lpb_pkg::IRQ_FRAME];
	endproperty
	a_frame: assert property (p_frame) else $error("end of frame not flagged");
	property p_last_line;
		@(posedge i_clock) disable iff (i_rst) (i_line_blank && i_last_line && i_fetch_idle)
			|-> ##2 (status_r[lpb_pkg::IRQ_LAST_LINE] && status_r[lpb_pkg::IRQ_LINE]);
	endproperty
	a_last_line: assert property (p_last_line) else $error("line events not flagged");
	property p_fetch_power;
		@(posedge i_clock) disable iff (i_rst) o_fetch_run |-> $past(core_on);
	endproperty
	a_fetch_power: assert property (p_fetch_power) else $error("fetch without power");
	property p_busy;
		@(posedge i_clock) disable iff (i_rst) core_on |=> busy_r;
	endproperty
	a_busy: assert property (p_busy) else $error("busy low while powered");
	property p_tft_lanes;
		@(posedge i_clock) disable iff (i_rst)
			(core_on && ctrl_two_r[1:0] == lpb_pkg::TYPE_TFT && !$changed(ctrl_two_r))
			|=> o_panel_data_bus == {$past(i_pix_blue), $past(i_pix_green), $past(i_pix_red)};
	endproperty
	a_tft_lanes: assert property (p_tft_lanes) else $error("colour lanes wrong");
	property p_dual8;
		@(posedge i_clock) disable iff (i_rst) (core_on && dual_scan
			&& ctrl_two_r[1:0] != lpb_pkg::TYPE_TFT && ctrl_two_r[4:3] == lpb_pkg::WIDTH_8)
			|=> o_panel_data_bus[23:8] == 16'h0000;
	endproperty
	a_dual8: assert property (p_dual8) else $error("upper lanes driven in 8-bit dual");
endmodule

// File: tb/lpb_panel_model.sv
// Panel module model that samples the pixel bus on each pixel clock rise
module lpb_panel_model (
	input wire logic i_clock,
	input wire logic i_pixel_clock_out,
	input wire logic [23:0] i_panel_data_bus,
	output logic [15:0] o_rise_count,
	output logic [23:0] o_sampled_bus
);
	timeunit 1ns;
	timeprecision 1ps;
	// Previous pixel clock level, for edge detection on the core clock
	logic pclk_r = 1'b0;
	logic [15:0] rise_cnt = 16'h0000; // Pixel clock rises seen
	logic [23:0] lane_cap = 24'h00_0000; // Lanes latched at the last rise
	assign o_rise_count = rise_cnt;
	assign o_sampled_bus = lane_cap;
	// ****************************************
	// Panel capture
	// ****************************************
	// Counts pixel clock rises and latches the lanes like a panel would
	always @(posedge i_clock) begin
		pclk_r <= i_pixel_clock_out;
		if (i_pixel_clock_out && !pclk_r) begin
			rise_cnt <= rise_cnt + 16'h0001;
			lane_cap <= i_panel_data_bus;
		end
	end
endmodule

// File: tb/lpb_core_tb_top.sv
// Self-checking bench for the panel bus, interrupt and bring-up block
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin err_total++; \
	$display("unexpected %s exp=%0h got=%0h", nm, ex, gt); end end
module lpb_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Stimulus signals
	// ****************************************
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] adr = 12'h000;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic wait_req;
	logic bus_err = 1'b0, xfer = 1'b0, ser_rd = 1'b0, f_empty = 1'b0;
	logic f_wr = 1'b0, f_full = 1'b0, reload = 1'b0, blank = 1'b0;
	logic last = 1'b0, idle = 1'b0;
	logic [23:0] lanes;
	logic pclk, run, irq;
	logic [31:0] up_base, lo_base, win_cfg, frm_cfg;
	logic [15:0] rises;
	logic [23:0] seen_bus;
	int err_total = 0;
	int total_checks = 0;
	// Core clock, 100 MHz
	always #5 clk = ~clk;
	lpb_core DUT (.i_clock(clk), .i_rst(rst), .i_avm_address(adr), .i_avm_read(rd_en),
		.i_avm_write(wr_en), .i_avm_writedata(wdat), .o_avm_readdata(rdat),
		.o_avm_waitrequest(wait_req), .i_bus_error(bus_err), .i_fetch_transfer(xfer),
		.i_serializer_read(ser_rd), .i_fifo_empty(f_empty), .i_fetch_fifo_write(f_wr),
		.i_fifo_full(f_full), .i_frame_reload(reload), .i_line_blank(blank),
		.i_last_line(last), .i_fetch_idle(idle), .i_pix_upper(8'hA5), .i_pix_lower(8'h3C),
		.i_pix_red(8'h12), .i_pix_green(8'h34), .i_pix_blue(8'h56),
		.o_panel_data_bus(lanes), .o_pixel_clock_out(pclk), .o_fetch_run(run),
		.o_upper_frame_base(up_base), .o_lower_frame_base(lo_base),
		.o_fetch_frame_config(frm_cfg), .o_window_addressing_config(win_cfg), .o_irq(irq));
	lpb_panel_model PANEL (.i_clock(clk), .i_pixel_clock_out(pclk),
		.i_panel_data_bus(lanes), .o_rise_count(rises), .o_sampled_bus(seen_bus));
	// ****************************************
	// Bus tasks
	// ****************************************
	// One Avalon access; holds the request until waitrequest is sampled low
	task automatic xfer_bus(input logic [11:0] a, input logic [31:0] d, input logic w,
		output logic [31:0] q);
		adr <= a;
		wdat <= d;
		wr_en <= w;
		rd_en <= !w;
		// Waits as long as the slave wants; only the watchdog ends a hang
		do begin
			@(posedge clk);
		end while (wait_req !== 1'b0);
		q = rdat;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer_bus(a, d, 1'b1, q);
	endtask
	// Reads a register and compares it with the expected word
	task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer_bus(a, 32'h0000_0000, 1'b0, q);
		`CHK("register", e, q)
	endtask
	// Drives one interrupt cause for one cycle, or only incomplete causes for k above 5, then waits out the latency
	task automatic fire(input int k);
		case (k)
			0: begin blank <= 1'b1; idle <= 1'b1; end
			1: begin blank <= 1'b1; idle <= 1'b1; last <= 1'b1; end
			2: reload <= 1'b1;
			3: begin ser_rd <= 1'b1; f_empty <= 1'b1; end
			4: begin f_wr <= 1'b1; f_full <= 1'b1; end
			5: begin bus_err <= 1'b1; xfer <= 1'b1; end
			default: begin blank <= 1'b1; ser_rd <= 1'b1; f_wr <= 1'b1; bus_err <= 1'b1; end
		endcase
		@(posedge clk);
		{blank, idle, last, reload, ser_rd, f_empty, f_wr, f_full, bus_err, xfer} <= 10'h000;
		repeat (4) @(posedge clk);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset_vals();
		chk_rd(lpb_pkg::OFS_CTRL_ONE, lpb_pkg::RST_CTRL_ONE);
		chk_rd(lpb_pkg::OFS_POWER, lpb_pkg::RST_POWER);
		chk_rd(lpb_pkg::OFS_DITHER_FIRST, lpb_pkg::RST_DITHER[0]);
		chk_rd(lpb_pkg::OFS_DITHER_LAST, lpb_pkg::RST_DITHER[7]);
		wr(12'h808, 32'h0000_0000);
		wr(12'h818, 32'hFFFF_FFFF);
		chk_rd(12'h818, 32'h0000_0000);
		chk_rd(lpb_pkg::OFS_IRQ_MASK, 32'h0000_0000);
	endtask
	// Applied fetch set: single scan, window mode off, dual scan commit
	task automatic t_applied();
		wr(lpb_pkg::OFS_UPPER_BASE, 32'h1000_0000);
		wr(lpb_pkg::OFS_LOWER_BASE, 32'h2000_0000);
		wr(lpb_pkg::OFS_WINDOW_CFG, 32'h0000_0055);
		repeat (2) @(posedge clk);
		`CHK("upper base", 32'h1000_0000, up_base)
		`CHK("lower base", 32'h0000_0000, lo_base)
		`CHK("window cfg", 32'h0000_0000, win_cfg)
		wr(lpb_pkg::OFS_CTRL_TWO, 32'h0000_000C);
		repeat (2) @(posedge clk);
		`CHK("lower held", 32'h0000_0000, lo_base)
		wr(lpb_pkg::OFS_FETCH_CTRL, 32'h0000_0004);
		repeat (2) @(posedge clk);
		`CHK("lower commit", 32'h2000_0000, lo_base)
		chk_rd(lpb_pkg::OFS_FETCH_CTRL, 32'h0000_0000);
		// A spent commit must not let later changes through
		wr(lpb_pkg::OFS_LOWER_BASE, 32'h3000_0000);
		wr(lpb_pkg::OFS_FRAME_CFG, 32'h0000_12C0);
		repeat (2) @(posedge clk);
		`CHK("lower no commit", 32'h2000_0000, lo_base)
		`CHK("frame held", 32'h0000_0000, frm_cfg)
		wr(lpb_pkg::OFS_FETCH_CTRL, 32'h0000_000C);
		repeat (2) @(posedge clk);
		`CHK("window cfg on", 32'h0000_0055, win_cfg)
		`CHK("lower second commit", 32'h3000_0000, lo_base)
		`CHK("frame cfg", 32'h0000_12C0, frm_cfg)
		chk_rd(lpb_pkg::OFS_FETCH_CTRL, 32'h0000_0008);
	endtask
	// Bring-up order, pixel clock rates, lane maps and shutdown
	task automatic t_power();
		logic [15:0] c0;
		logic [31:0] mode [4] = '{32'h08, 32'h0C, 32'h14, 32'h02};
		logic [23:0] lane [4] = '{24'h0000A5, 24'h0000C5, 24'h003CA5, 24'h563412};
		wr(lpb_pkg::OFS_CTRL_TWO, 32'h0000_0008);
		wr(lpb_pkg::OFS_FETCH_CTRL, 32'h0000_0001);
		repeat (3) @(posedge clk);
		`CHK("fetch before power", 1'b0, run)
		wr(lpb_pkg::OFS_POWER, 32'h0000_000F);
		repeat (2) @(posedge clk);
		`CHK("fetch run", 1'b1, run)
		chk_rd(lpb_pkg::OFS_POWER, 32'h8000_000F);
		c0 = rises;
		repeat (60) @(posedge clk);
		`CHK("pixel clock div", 16'h000A, rises - c0)
		wr(lpb_pkg::OFS_CTRL_ONE, 32'h0000_2001);
		repeat (4) @(posedge clk);
		c0 = rises;
		repeat (60) @(posedge clk);
		`CHK("pixel clock bypass", 16'h001E, rises - c0)
		// Four edges so that the panel has latched the new lanes on a rise
		for (int i = 0; i < 4; i++) begin
			wr(lpb_pkg::OFS_CTRL_TWO, mode[i]);
			repeat (4) @(posedge clk);
			`CHK("lanes", lane[i], lanes)
			`CHK("panel sees", lane[i], seen_bus)
		end
		wr(lpb_pkg::OFS_POWER, 32'h0000_000E);
		repeat (3) @(posedge clk);
		`CHK("fetch off", 1'b0, run)
		`CHK("lanes off", 24'h00_0000, lanes)
		wr(lpb_pkg::OFS_FETCH_CTRL, 32'h0000_0000);
		chk_rd(lpb_pkg::OFS_POWER, 32'h8000_000E);
		fire(0);
		chk_rd(lpb_pkg::OFS_POWER, 32'h0000_000E);
		`CHK("pixel clock idle", 1'b0, pclk)
	endtask
	// Enable, fire, status and clear of all six sources, then masking of the frame source
	task automatic t_irq();
		wr(lpb_pkg::OFS_IRQ_CLEAR, 32'h0000_003F);
		wr(lpb_pkg::OFS_IRQ_ENABLE, 32'h0000_003F);
		chk_rd(lpb_pkg::OFS_IRQ_MASK, 32'h0000_003F);
		chk_rd(lpb_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
		for (int k = 0; k < 6; k++) begin
			fire(k);
			`CHK("irq out", 1'b1, irq)
			chk_rd(lpb_pkg::OFS_IRQ_STATUS, (k == 1) ? 32'h3 : (32'h1 << k));
			wr(lpb_pkg::OFS_IRQ_CLEAR, 32'h0000_003F);
			chk_rd(lpb_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
		end
		fire(6);
		chk_rd(lpb_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
		wr(lpb_pkg::OFS_IRQ_DISABLE, 32'h0000_0004);
		chk_rd(lpb_pkg::OFS_IRQ_MASK, 32'h0000_003B);
		fire(2);
		`CHK("masked irq", 1'b0, irq)
		chk_rd(lpb_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
	endtask
	// ****************************************
	// Run control
	// ****************************************
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Watchdog, well beyond the few hundred cycles the run needs
	initial begin
		#300000;
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset_vals();
		t_applied();
		t_power();
		t_irq();
		report_and_stop();
	end
endmodule
